// ==== hdl/cpu_poll_defines.svh ====
`ifndef CPU_POLL_DEFINES_SVH
`define CPU_POLL_DEFINES_SVH

// Register offsets
`define REG_CH1_READ   8'h1a
`define REG_CH2_READ   8'h1b
`define REG_CH3_READ   8'h1c
`define REG_CH0_READ   8'h33
`define REG_LOW_LIMIT  8'h34
`define REG_HIGH_LIMIT 8'h35
`define REG_SMOOTH_CFG 8'h36
`define REG_CONFIG1    8'h40
`define REG_STATUS3    8'h43
`define REG_STATUS2    8'h81
`define REG_CPU_CFG    8'h88
`define REG_OFS0       8'h94
`define REG_OFS1       8'h95
`define REG_OFS2       8'h96
`define REG_OFS3       8'h97

// Field positions
`define MON_EN_BIT     4
`define CPU_CNT_MSB    7
`define CPU_CNT_LSB    6
`define DOM0_BIT       3
`define DOM1_BIT       5
`define DOM2_BIT       4
`define DOM3_BIT       3
`define AVG_MSB        2
`define STS_LIM0       0
`define STS_DERR       1
`define STS_FERR       2

// Reset values
`define LOW_LIMIT_RST  8'h81
`define HIGH_LIMIT_RST 8'h00
`define CFG_RST        8'h00

// Frame contents
`define CPU_ADDR_BASE  8'h30
`define WRITE_LEN      8'h01
`define READ_LEN       8'h02
`define CMD_TEMP_DOM0  8'h01
`define CMD_TEMP_DOM1  8'h02
`define ERR_CODE_LO    16'h8000
`define ERR_CODE_HI    16'h8003

// Timing
`define CLK_NS         10
`define IDLE_NS        14000
`define IDLE_CYC       ((`IDLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== hdl/cpu_poll_pkg.sv ====
package cpu_poll_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TX,
        ST_RX,
        ST_GAP
    } link_state_t;

endpackage : cpu_poll_pkg

// ==== hdl/cpu_thermal_poller.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpu_poll_defines.svh"

// Summary of operation
// R1 - Four channels; this block serves the CPU one
// R2 - Block originates every poll of the CPUs
// R3 - Readings are negative margins below throttle point
// R4 - Relative readings stored and sent to fans
// R5 - Polling runs only while monitor enable set; a round already under way when it clears still runs to the end of its gap
// R6 - Two-bit field selects one to four CPUs
// R7 - Each channel addresses its own CPU target
// R8 - CPU targets map to four reading registers
// R9 - Per-channel domain-count bit selects one/two domains
// R10 - Two domains: keep only the hotter value
// R11 - All channels share one limit pair
// R12 - Low limit resets 0x81, high 0x00
// R13 - Each channel has its own offset register
// R14 - Offset is signed, one degree per bit
// R15 - Offset added to hottest value, then compared
// R16 - Error code: flag, add zero, not stored
// R17 - Bad check sequence: flag and raise alert
// R18 - Per-channel limit flags raise the alert
// R19 - Average over set count, 14 us gap
module cpu_thermal_poller #(
    parameter int BIT_CYC = 100
) (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire cpu_poll_pkg::reg_req_t reg_req,
    output logic [7:0]                  reg_rdata,
    input  wire logic                   cpu_link_in,
    output logic                        cpu_link_out,
    output logic                        cpu_link_oe_n,
    output logic [3:0][7:0]             fan_temp,
    output logic                        alert_output_n
);

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
    localparam logic [15:0] Q1       = 16'(BIT_CYC / 4);
    localparam logic [15:0] Q3       = 16'(3 * BIT_CYC / 4);
    localparam logic [15:0] HALF     = 16'(BIT_CYC / 2);
    localparam logic [10:0] GAP_LAST = 11'(`IDLE_CYC - 1);

    logic                      rst_meta_r;
    logic                      rst_n;
    logic                      link_s1_r;
    logic                      link_s2_r;
    logic [7:0]                cfg1_r;
    logic [7:0]                smooth_r;
    logic [7:0]                cpucfg_r;
    logic [7:0]                low_r;
    logic [7:0]                high_r;
    logic [3:0][7:0]           ofs_r;
    logic [3:0][7:0]           rd_r;
    logic [3:0][15:0]          sum_r;
    logic [2:0]                sts43_r;
    logic [2:0]                sts81_r;
    cpu_poll_pkg::link_state_t state_r;
    logic [15:0]               bit_cnt_r;
    logic [5:0]                idx_r;
    logic [39:0]               tx_sh_r;
    logic [22:0]               rx_sh_r;
    logic                      rx_bit_r;
    logic [7:0]                crc_r;
    logic [1:0]                ch_r;
    logic                      dom_r;
    logic [7:0]                round_r;
    logic [10:0]               gap_r;
    logic [7:0]                best_r;
    logic                      best_ok_r;

    // Async assert, synchronous release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_s1_r <= 1'b0;
            link_s2_r <= 1'b0;
        end else begin
            link_s1_r <= cpu_link_in;
            link_s2_r <= link_s1_r;
        end
    end

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? 8'h07 : 8'h00);
    endfunction : crc_step

    function automatic logic [39:0] frame_word(input logic [1:0] ch, input logic dom);
        frame_word = {`CPU_ADDR_BASE + {6'h00, ch}, `WRITE_LEN, `READ_LEN,
                      dom ? `CMD_TEMP_DOM1 : `CMD_TEMP_DOM0, 8'h00};
    endfunction : frame_word

    // Configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg1_r   <= `CFG_RST;
            smooth_r <= `CFG_RST;
            cpucfg_r <= `CFG_RST;
            low_r    <= `LOW_LIMIT_RST;  // R12
            high_r   <= `HIGH_LIMIT_RST; // R12
            ofs_r    <= '0;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `REG_CONFIG1:    cfg1_r   <= reg_req.wdata;
                `REG_SMOOTH_CFG: smooth_r <= reg_req.wdata;
                `REG_CPU_CFG:    cpucfg_r <= reg_req.wdata;
                `REG_LOW_LIMIT:  low_r    <= reg_req.wdata;
                `REG_HIGH_LIMIT: high_r   <= reg_req.wdata;
                `REG_OFS0, `REG_OFS1, `REG_OFS2, `REG_OFS3: begin
                    ofs_r[reg_req.addr[1:0]] <= reg_req.wdata; // R13 R14
                end
                default: ;
            endcase
        end
    end

    logic       mon_en;
    logic [1:0] last_ch;
    logic [3:0] two_dom;
    logic [2:0] avg_code;
    logic [7:0] last_round;
    assign mon_en     = cfg1_r[`MON_EN_BIT]; // R5
    assign last_ch    = cpucfg_r[`CPU_CNT_MSB:`CPU_CNT_LSB]; // R6
    assign two_dom    = {cpucfg_r[`DOM3_BIT], cpucfg_r[`DOM2_BIT],
                         cpucfg_r[`DOM1_BIT], smooth_r[`DOM0_BIT]}; // R9
    assign avg_code   = smooth_r[`AVG_MSB:0];
    assign last_round = (8'h01 << avg_code) - 8'h01; // R19

    // Bit timing and frame decode
    logic        bit_end;
    logic        cur_bit;
    logic [7:0]  crc_nxt;
    logic        frame_end;
    logic [23:0] rx_word;
    logic [15:0] temp;
    logic        fcs_bad;
    logic        derr;
    logic        val_ok;
    logic [7:0]  val8;
    assign bit_end   = bit_cnt_r == BIT_LAST;
    assign cur_bit   = (state_r == cpu_poll_pkg::ST_TX) ? tx_sh_r[39] : rx_bit_r;
    assign crc_nxt   = crc_step(crc_r, cur_bit);
    assign frame_end = state_r == cpu_poll_pkg::ST_RX && bit_end && idx_r == 6'd63;
    assign rx_word   = {rx_sh_r, rx_bit_r};
    // Low byte arrives first
    assign temp      = {rx_word[15:8], rx_word[23:16]};
    // Running check covers the whole frame, so a good one ends at zero
    assign fcs_bad   = crc_nxt != 8'h00; // R17
    assign derr      = !fcs_bad && temp >= `ERR_CODE_LO && temp <= `ERR_CODE_HI; // R16
    assign val_ok    = !fcs_bad && !derr;
    // Whole degrees of a negative margin; no conversion to absolute
    assign val8      = temp[13:6]; // R3 R4

    // Hotter domain is the larger (closer to zero) margin
    logic       prev_ok;
    logic       hot_ok;
    logic [7:0] hot;
    logic [8:0] adj;
    logic [7:0] contrib;
    logic       dom_last;
    logic       chan_done;
    logic       round_end;
    logic       store;
    assign prev_ok   = dom_r && best_ok_r;
    assign hot_ok    = val_ok || prev_ok;
    assign hot       = (!val_ok || (prev_ok && $signed(best_r) > $signed(val8)))
                       ? best_r : val8; // R10
    assign adj       = {hot[7], hot} + {ofs_r[ch_r][7], ofs_r[ch_r]}; // R15
    // Saturate rather than wrap past the signed range
    assign contrib   = !hot_ok ? 8'h00 : (adj[8] != adj[7]) ?
                       (adj[8] ? 8'h80 : 8'h7f) : adj[7:0]; // R16
    assign dom_last  = dom_r || !two_dom[ch_r]; // R9
    assign chan_done = frame_end && dom_last;
    assign round_end = chan_done && ch_r == last_ch;
    // At or past the count, so lowering the count never stalls refresh
    assign store     = round_end && round_r >= last_round; // R19

    logic [3:0][15:0] tot;
    logic [3:0][7:0]  avg;
    logic [3:0]       lim_hit;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tot[i] = sum_r[i] + ((chan_done && ch_r == 2'(i))
                     ? {{8{contrib[7]}}, contrib} : 16'h0000);
            avg[i] = 8'($signed(tot[i]) >>> avg_code);
            // One shared limit pair for every channel
            lim_hit[i] = $signed(avg[i]) < $signed(low_r)
                      || $signed(avg[i]) > $signed(high_r); // R11
        end
    end

    // Poll sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= cpu_poll_pkg::ST_IDLE;
            bit_cnt_r <= 16'h0000;
            idx_r     <= 6'd0;
            tx_sh_r   <= 40'h00_0000_0000;
            rx_sh_r   <= 23'h00_0000;
            rx_bit_r  <= 1'b0;
            crc_r     <= 8'h00;
            ch_r      <= 2'd0;
            dom_r     <= 1'b0;
            round_r   <= 8'h00;
            gap_r     <= 11'h000;
        end else begin
            case (state_r)
                cpu_poll_pkg::ST_IDLE: begin
                    ch_r    <= 2'd0;
                    dom_r   <= 1'b0;
                    round_r <= 8'h00;
                    if (mon_en) begin // R2 R5
                        state_r   <= cpu_poll_pkg::ST_TX;
                        tx_sh_r   <= frame_word(2'd0, 1'b0);
                        crc_r     <= 8'h00;
                        idx_r     <= 6'd0;
                        bit_cnt_r <= 16'h0000;
                    end
                end
                cpu_poll_pkg::ST_TX: begin
                    bit_cnt_r <= bit_end ? 16'h0000 : bit_cnt_r + 16'h0001;
                    if (bit_end) begin
                        crc_r   <= crc_nxt;
                        idx_r   <= idx_r + 6'd1;
                        tx_sh_r <= (idx_r == 6'd31) ? {crc_nxt, 32'h0000_0000}
                                                    : {tx_sh_r[38:0], 1'b0};
                        if (idx_r == 6'd39) begin
                            state_r <= cpu_poll_pkg::ST_RX;
                        end
                    end
                end
                cpu_poll_pkg::ST_RX: begin
                    bit_cnt_r <= bit_end ? 16'h0000 : bit_cnt_r + 16'h0001;
                    if (bit_cnt_r == HALF) begin
                        rx_bit_r <= link_s2_r;
                    end
                    if (bit_end) begin
                        crc_r   <= crc_nxt;
                        idx_r   <= idx_r + 6'd1;
                        rx_sh_r <= rx_word[22:0];
                    end
                    if (frame_end) begin
                        crc_r     <= 8'h00;
                        idx_r     <= 6'd0;
                        bit_cnt_r <= 16'h0000;
                        if (!dom_last) begin
                            dom_r   <= 1'b1;
                            state_r <= cpu_poll_pkg::ST_TX;
                            tx_sh_r <= frame_word(ch_r, 1'b1); // R7
                        end else if (ch_r != last_ch) begin
                            ch_r    <= ch_r + 2'd1;
                            dom_r   <= 1'b0;
                            state_r <= cpu_poll_pkg::ST_TX;
                            tx_sh_r <= frame_word(ch_r + 2'd1, 1'b0); // R7
                        end else begin
                            ch_r    <= 2'd0; // R6
                            dom_r   <= 1'b0;
                            round_r <= store ? 8'h00 : round_r + 8'h01;
                            gap_r   <= 11'h000;
                            state_r <= cpu_poll_pkg::ST_GAP;
                        end
                    end
                end
                cpu_poll_pkg::ST_GAP: begin
                    gap_r <= gap_r + 11'h001;
                    if (gap_r == GAP_LAST) begin // R19
                        if (mon_en) begin
                            state_r   <= cpu_poll_pkg::ST_TX;
                            tx_sh_r   <= frame_word(2'd0, 1'b0);
                            bit_cnt_r <= 16'h0000;
                        end else begin
                            state_r <= cpu_poll_pkg::ST_IDLE;
                        end
                    end
                end
                default: state_r <= cpu_poll_pkg::ST_IDLE;
            endcase
        end
    end

    // Line driver: high for the bit's mark, released while the CPU answers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_link_out  <= 1'b0;
            cpu_link_oe_n <= 1'b0;
        end else if (state_r == cpu_poll_pkg::ST_TX) begin
            cpu_link_out  <= bit_cnt_r < (tx_sh_r[39] ? Q3 : Q1);
            cpu_link_oe_n <= 1'b0;
        end else if (state_r == cpu_poll_pkg::ST_RX) begin
            cpu_link_out  <= bit_cnt_r < Q1;
            cpu_link_oe_n <= bit_cnt_r >= Q1;
        end else begin
            cpu_link_out  <= 1'b0;
            cpu_link_oe_n <= 1'b0;
        end
    end

    // Domain tracking, averaging and reading registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            best_r    <= 8'h00;
            best_ok_r <= 1'b0;
            sum_r     <= '0;
            rd_r      <= '0;
        end else if (state_r == cpu_poll_pkg::ST_IDLE) begin
            sum_r     <= '0;
            best_ok_r <= 1'b0;
        end else if (frame_end) begin
            best_r    <= hot;
            best_ok_r <= hot_ok && !dom_last;
            for (int i = 0; i < 4; i++) begin
                if (store) begin
                    sum_r[i] <= 16'h0000;
                    if (2'(i) <= last_ch) begin
                        rd_r[i] <= avg[i]; // R4 R8 R19
                    end
                end else begin
                    sum_r[i] <= tot[i]; // R16
                end
            end
        end
    end

    // Status flags; a set in the same cycle as a read wins
    logic rd43;
    logic rd81;
    assign rd43 = reg_req.rd && reg_req.addr == `REG_STATUS3;
    assign rd81 = reg_req.rd && reg_req.addr == `REG_STATUS2;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sts43_r <= 3'b000;
            sts81_r <= 3'b000;
        end else begin
            sts43_r[`STS_LIM0] <= (store && lim_hit[0])
                               || (sts43_r[`STS_LIM0] && !rd43); // R18
            sts43_r[`STS_DERR] <= (frame_end && derr)
                               || (sts43_r[`STS_DERR] && !rd43); // R16
            sts43_r[`STS_FERR] <= (frame_end && fcs_bad)
                               || (sts43_r[`STS_FERR] && !rd43); // R17
            for (int i = 1; i < 4; i++) begin
                sts81_r[i-1] <= (store && lim_hit[i] && 2'(i) <= last_ch)
                             || (sts81_r[i-1] && !rd81); // R18
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_output_n <= 1'b1;
        end else begin
            alert_output_n <= !(|sts43_r || |sts81_r); // R17 R18
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `REG_CH0_READ:   reg_rdata <= rd_r[0]; // R8
                `REG_CH1_READ:   reg_rdata <= rd_r[1];
                `REG_CH2_READ:   reg_rdata <= rd_r[2];
                `REG_CH3_READ:   reg_rdata <= rd_r[3];
                `REG_LOW_LIMIT:  reg_rdata <= low_r;
                `REG_HIGH_LIMIT: reg_rdata <= high_r;
                `REG_SMOOTH_CFG: reg_rdata <= smooth_r;
                `REG_CONFIG1:    reg_rdata <= cfg1_r;
                `REG_CPU_CFG:    reg_rdata <= cpucfg_r;
                `REG_STATUS3:    reg_rdata <= {5'h00, sts43_r};
                `REG_STATUS2:    reg_rdata <= {2'h0, sts81_r, 3'h0};
                `REG_OFS0, `REG_OFS1, `REG_OFS2, `REG_OFS3: begin
                    reg_rdata <= ofs_r[reg_req.addr[1:0]];
                end
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end

    assign fan_temp = rd_r; // R1 R4

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence gap_enter_s;
        state_r == cpu_poll_pkg::ST_RX ##1 state_r == cpu_poll_pkg::ST_GAP;
    endsequence

    idle_gate_a: assert property ( // R5
        state_r == cpu_poll_pkg::ST_IDLE && !mon_en |=> state_r == cpu_poll_pkg::ST_IDLE)
        else $error("poll started while monitoring disabled");
    target_addr_a: assert property ( // R7
        $rose(state_r == cpu_poll_pkg::ST_TX) || (frame_end && !store && !round_end)
        |=> tx_sh_r[39:32] == `CPU_ADDR_BASE + {6'h00, ch_r})
        else $error("frame target does not match channel");
    ch_wrap_a: assert property ( // R6
        round_end |=> ch_r == 2'd0 && state_r == cpu_poll_pkg::ST_GAP)
        else $error("channel did not wrap after last cpu");
    data_err_a: assert property ( // R16
        frame_end && derr |=> sts43_r[`STS_DERR] ##1 !alert_output_n)
        else $error("data error not flagged");
    fcs_err_a: assert property ( // R17
        frame_end && fcs_bad |=> sts43_r[`STS_FERR] ##1 !alert_output_n)
        else $error("check sequence error not flagged");
    limit_flag_a: assert property ( // R11
        store && lim_hit[0] |=> sts43_r[`STS_LIM0] && rd_r[0] == $past(avg[0]))
        else $error("channel zero limit flag missing");
    gap_hold_a: assert property ( // R19
        gap_enter_s |-> (state_r == cpu_poll_pkg::ST_GAP)[*8])
        else $error("idle gap too short");
    hottest_a: assert property ( // R10
        frame_end && val_ok && prev_ok
        |-> $signed(hot) >= $signed(val8) && $signed(hot) >= $signed(best_r))
        else $error("cooler domain kept");

endmodule : cpu_thermal_poller

`default_nettype wire

// ==== tb/cpu_client_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpu_client_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic                  sys_clk,
    input  wire logic                  nrst,
    input  wire logic                  wire_lvl,
    input  wire logic [3:0][1:0][15:0] temps,
    input  wire logic                  bad_fcs,
    output logic                       drv
);
    logic        prev_r;
    logic [5:0]  bn_r;
    int          cnt_r;
    logic [7:0]  crc_r;
    logic [7:0]  sh_r;
    logic [7:0]  addr_r;
    logic [7:0]  cmd_r;
    logic [15:0] word;
    logic [15:0] resp;
    int          k;
    logic        rb;
    logic        smp;
    always_comb begin
        word = temps[addr_r[1:0]][cmd_r == 8'h02];
        resp = {word[7:0], word[15:8]};
        k = int'(bn_r) - 40;
        rb = (k < 0) ? 1'b0 : (k < 16) ? resp[15 - k] : crc_r[23 - k] ^ bad_fcs;
        smp = (bn_r < 6'd40) ? wire_lvl : rb;
        // Released line falls to the pull-down level
        drv = (bn_r >= 6'd40) && rb && (cnt_r < 3 * BIT_CYC / 4);
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_r <= 1'b0;
            bn_r <= 6'd63;
            cnt_r <= 0;
            crc_r <= 8'h00;
            sh_r <= 8'h00;
            addr_r <= 8'h00;
            cmd_r <= 8'h00;
        end else begin
            prev_r <= wire_lvl;
            if (wire_lvl && !prev_r) begin
                cnt_r <= 0;
                bn_r <= bn_r + 6'd1;
                if (bn_r == 6'd63) crc_r <= 8'h00;
            end else begin
                cnt_r <= cnt_r + 1;
            end
            if (cnt_r == BIT_CYC / 2 && bn_r < 6'd56) begin
                crc_r <= {crc_r[6:0], 1'b0} ^ ((crc_r[7] ^ smp) ? 8'h07 : 8'h00);
                sh_r <= {sh_r[6:0], smp};
                if (bn_r == 6'd7) addr_r <= {sh_r[6:0], smp};
                if (bn_r == 6'd31) cmd_r <= {sh_r[6:0], smp};
            end
        end
    end
endmodule : cpu_client_model
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int BIT = 16;
    localparam logic [3:0][7:0] RA = {8'h1c, 8'h1b, 8'h1a, 8'h33};
    logic                   sys_clk;
    logic                   nrst;
    cpu_poll_pkg::reg_req_t reg_req;
    logic [7:0]             reg_rdata;
    logic                   link_out;
    logic                   link_oe_n;
    logic [3:0][7:0]        fan_temp;
    logic                   alert_n;
    logic                   drv;
    wire logic              wire_lvl;
    logic [3:0][1:0][15:0]  temps;
    logic                   bad_fcs;
    logic [3:0]             two;
    logic [3:0][7:0]        ofs;
    logic [31:0]            seed = 32'h310b;
    logic [7:0]             r;
    logic                   prev = 1'b0;
    int                     edges = 0;
    int                     cyc = 0;
    int                     fail_count = 0;
    int                     checks_done = 0;
    assign wire_lvl = link_oe_n ? drv : link_out;
    cpu_thermal_poller #(.BIT_CYC(BIT)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .cpu_link_in(wire_lvl), .cpu_link_out(link_out),
        .cpu_link_oe_n(link_oe_n), .fan_temp(fan_temp), .alert_output_n(alert_n));
    cpu_client_model #(.BIT_CYC(BIT)) cpu_u (.sys_clk(sys_clk), .nrst(nrst), .wire_lvl(wire_lvl),
        .temps(temps), .bad_fcs(bad_fcs), .drv(drv));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    // Whole run is about 57k cycles
    always @(posedge sys_clk) begin
        prev <= wire_lvl;
        if (wire_lvl && !prev) edges <= edges + 1;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: run did not finish", $time);
            results();
        end
    end
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask : chk_bit
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic err(input logic [15:0] t);
        return t >= 16'h8000 && t <= 16'h8003;
    endfunction : err
    function automatic logic [7:0] exp_rd(input int ch);
        logic v0;
        logic v1;
        int   best;
        int   s;
        v0 = !err(temps[ch][0]);
        v1 = two[ch] && !err(temps[ch][1]);
        // A channel without a valid domain reads zero, offset skipped
        if (!v0 && !v1) return 8'h00;
        best = v0 ? int'($signed(temps[ch][0][13:6])) : -1000;
        if (v1 && int'($signed(temps[ch][1][13:6])) > best) best = $signed(temps[ch][1][13:6]);
        s = best + int'($signed(ofs[ch]));
        s = (s > 127) ? 127 : (s < -128) ? -128 : s;
        return 8'(s);
    endfunction : exp_rd
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        reg_req <= '0;
        @(posedge sys_clk);
        #1 d = reg_rdata;
    endtask : reg_rd
    task automatic wait_rounds(input int n);
        int c;
        c = 1600;
        for (int ch = 0; ch < 4; ch++) c += (two[ch] ? 2 : 1) * 64 * BIT;
        repeat (n * c) @(posedge sys_clk);
    endtask : wait_rounds
    task automatic idle_chk(input int n);
        int saved;
        saved = edges;
        repeat (n) @(posedge sys_clk);
        chk_bit(edges != saved, 1'b0);
    endtask : idle_chk
    task automatic check_all();
        for (int ch = 0; ch < 4; ch++) begin
            reg_rd(RA[ch], r);
            chk_byte(r, exp_rd(ch));
            chk_byte(fan_temp[ch], exp_rd(ch));
        end
    endtask : check_all
    initial begin
        reg_req = '0;
        nrst = 1'b0;
        temps = '0;
        bad_fcs = 1'b0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reg_rd(8'h34, r);
        chk_byte(r, 8'h81);
        reg_rd(8'h35, r);
        chk_byte(r, 8'h00);
        reg_wr(8'h33, 8'h5a);
        reg_rd(8'h33, r);
        chk_byte(r, 8'h00);
        reg_rd(8'h50, r);
        chk_byte(r, 8'h00);
        idle_chk(500);
        reg_wr(8'h34, 8'h80);
        reg_wr(8'h35, 8'h7f);
        // Two-round average on the first pass
        reg_wr(8'h36, 8'h09);
        reg_wr(8'h88, 8'hf8);
        two = 4'hf;
        for (int ch = 0; ch < 4; ch++) begin
            r = 8'(xs());
            // Channel zero forces saturation at the negative end
            ofs[ch] = (ch == 0) ? 8'h80 : {{4{r[3]}}, r[3:0]};
            reg_wr(8'h94 + 8'(ch), ofs[ch]);
            reg_rd(8'h94 + 8'(ch), r);
            chk_byte(r, ofs[ch]);
            for (int d = 0; d < 2; d++) begin
                temps[ch][d] <= 16'(-64 - 64 * int'(xs() % 100) + int'(xs() & 32'h3f));
            end
        end
        reg_wr(8'h40, 8'h10);
        wait_rounds(2);
        reg_rd(8'h43, r);
        reg_rd(8'h81, r);
        check_all();
        temps[1][1] <= 16'h8001;
        temps[2][0] <= 16'h8000;
        temps[2][1] <= 16'h8003;
        temps[3][1] <= 16'hffc0;
        reg_wr(8'h88, 8'hf0);
        reg_wr(8'h36, 8'h08);
        two[3] = 1'b0;
        wait_rounds(2);
        chk_bit(alert_n, 1'b0);
        reg_rd(8'h43, r);
        chk_byte(r & 8'h02, 8'h02);
        check_all();
        temps[1][1] <= 16'hf000;
        temps[2] <= {16'hf100, 16'hf200};
        bad_fcs <= 1'b1;
        reg_wr(8'h34, 8'h7f);
        wait_rounds(1);
        chk_bit(alert_n, 1'b0);
        reg_rd(8'h43, r);
        chk_byte(r & 8'h05, 8'h05);
        reg_rd(8'h81, r);
        chk_byte(r & 8'h38, 8'h38);
        bad_fcs <= 1'b0;
        reg_wr(8'h34, 8'h80);
        reg_wr(8'h40, 8'h00);
        wait_rounds(1);
        reg_rd(8'h43, r);
        reg_rd(8'h81, r);
        reg_rd(8'h43, r);
        chk_byte(r, 8'h00);
        chk_bit(alert_n, 1'b1);
        idle_chk(2000);
        results();
    end
endmodule : tb_top
`default_nettype wire
